// ### rtl/awts_top.sv
// sequencer trigger unit with run, program and command table status
//
// Functional notes
// - force command triggers regardless of source settings
// - main trigger state shows detected or not
// - slope picks level, rise, fall or both
// - selected source compared against programmable level
// - re-arm after hysteresis excursion; zero disables it
// - hysteresis side opposite to the triggering edge
// - absolute or relative hysteresis, above full allowed
// - gate taken from trigger input 3 or 4
// - enabled gate blocks compare triggers while its input is low; disabled gate ignored
// - auxiliary source among eight trigger inputs/outputs
// - auxiliary trigger state flag of its own
// - one instruction executed per clock cycle
// - instruction counter readable while running
// - status ready, running, waiting or not ready
// - rerun restarts program whenever it completes
// - program holds at most 1024 instructions
// - command table status none, ok or error
`timescale 1ns/1ps
module awts_top
#(
   parameter int N_SRC = `AWTS_N_SRC
)
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic [N_SRC-1:0][`AWTS_SAMPLE_W-1:0] samples_in,
   input wire awts_pkg::awts_trig_cfg_type trig_cfg_in,
   input wire logic force_in,
   input wire logic trig_ack_in,
   input wire logic aux_ack_in,
   input wire logic [`AWTS_N_TRIG-1:0] trig_pin_in,
   input wire logic [`AWTS_N_TRIG-1:0] trig_out_in,
   input wire awts_pkg::awts_seq_ctl_type seq_ctl_in,
   input wire logic ct_ok_in,
   input wire logic ct_err_in,
   input wire logic ct_clear_in,
   output logic trig_pulse_out,
   output logic trig_state_out,
   output logic aux_state_out,
   output awts_pkg::awts_seq_stat_type seq_stat_out
);

   logic rst_meta_n_r;
   logic rst_n_r;
   awts_pkg::awts_state_type s_r;
   awts_pkg::awts_state_type s_nxt;
   logic [`AWTS_N_TRIG-1:0] pin_sync;
   logic signed [`AWTS_CMP_W-1:0] samp_x;
   logic signed [`AWTS_CMP_W-1:0] lvl_x;
   logic signed [`AWTS_CMP_W-1:0] hyst_x;
   logic [`AWTS_PROD_W-1:0] rel_prod;
   logic [`AWTS_PROD_W-1:0] rel_hyst;
   logic [`AWTS_HYST_W-1:0] hyst_c;
   logic hyst_nz;
   logic above;
   logic below_lo;
   logic above_hi;
   logic rise_x;
   logic fall_x;
   logic hit;
   logic rearm;
   logic qualify;
   logic gate_sig;
   logic gate_ok;
   logic ana_trig;
   logic trig_evt;
   logic [2*`AWTS_N_TRIG-1:0] aux_pool;
   logic aux_sig;
   logic aux_hit;
   logic prog_ok;
   logic last;
   logic adv;
   logic [`AWTS_USAGE_PROD_W-1:0] usage_prod;

   // reset is dropped at once and released on the clock
   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_meta_n_r <= 1'h0;
         rst_n_r <= 1'h0;
      end
      else
      begin
         rst_meta_n_r <= 1'h1;
         rst_n_r <= rst_meta_n_r;
      end
   end

   awts_sync3
   #(
      .WIDTH(`AWTS_N_TRIG)
   )
   u_pin_sync
   (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_r),
      .d_in(trig_pin_in),
      .q_out(pin_sync)
   );

   // analog compare datapath, all in one widened signed domain
   assign samp_x = `AWTS_CMP_W'($signed(samples_in[trig_cfg_in.src_sel]));
   assign lvl_x = `AWTS_CMP_W'($signed(trig_cfg_in.level));
   // relative size may exceed full scale; only the ceiling clamps it
   assign rel_prod = `AWTS_PROD_W'(trig_cfg_in.full_scale) *
                     `AWTS_PROD_W'(trig_cfg_in.hyst_pct);
   assign rel_hyst = rel_prod / `AWTS_PCT_FULL;
   always_comb
   begin
      if (!trig_cfg_in.hyst_rel)
         hyst_c = `AWTS_HYST_W'(trig_cfg_in.hyst_abs);
      else if (rel_hyst > `AWTS_PROD_W'(`AWTS_HYST_MAX))
         hyst_c = `AWTS_HYST_MAX;
      else
         hyst_c = rel_hyst[`AWTS_HYST_W-1:0];
   end
   assign hyst_x = $signed(`AWTS_CMP_W'(hyst_c));
   assign hyst_nz = (hyst_c != '0);
   assign above = (samp_x >= lvl_x);
   assign below_lo = (samp_x <= (lvl_x - hyst_x));
   assign above_hi = (samp_x >= (lvl_x + hyst_x));

   // edges from this and the previous comparator result
   assign rise_x = above & ~s_r.prev_above;
   assign fall_x = ~above & s_r.prev_above;

   always_comb
   begin
      unique case (trig_cfg_in.slope)
         awts_pkg::AWTS_SLOPE_LEVEL:
         begin
            hit = above;
            rearm = below_lo;
         end
         awts_pkg::AWTS_SLOPE_RISE:
         begin
            hit = rise_x;
            rearm = below_lo;
         end
         awts_pkg::AWTS_SLOPE_FALL:
         begin
            hit = fall_x;
            rearm = above_hi;
         end
         awts_pkg::AWTS_SLOPE_BOTH:
         begin
            hit = rise_x | fall_x;
            rearm = s_r.last_rise ? below_lo : above_hi;
         end
      endcase
   end

   // zero hysteresis leaves the trigger armed at all times
   assign qualify = hit & (s_r.armed | ~hyst_nz);
   assign gate_sig = trig_cfg_in.gate_sel ? pin_sync[`AWTS_GATE_IN_B] :
                     pin_sync[`AWTS_GATE_IN_A];
   assign gate_ok = ~trig_cfg_in.gate_en | gate_sig;
   assign ana_trig = qualify & gate_ok;
   assign trig_evt = ana_trig | force_in;

   // auxiliary pool: inputs 1..4 then outputs 1..4
   assign aux_pool = {trig_out_in, pin_sync};
   assign aux_sig = aux_pool[trig_cfg_in.aux_sel];
   assign aux_hit = aux_sig & ~s_r.aux_prev;

   assign prog_ok = seq_ctl_in.loaded & (seq_ctl_in.len != '0) &
                    (seq_ctl_in.len <= `AWTS_CACHE_INSTR);
   assign last = (`AWTS_LEN_W'(s_r.seq.pc) ==
                  (seq_ctl_in.len - `AWTS_LEN_ONE));
   assign usage_prod = `AWTS_USAGE_PROD_W'(seq_ctl_in.len) *
                       `AWTS_USAGE_PCT;

   always_comb
   begin
      s_nxt = s_r;
      adv = 1'h0;

      s_nxt.prev_above = above;
      if (ana_trig & hyst_nz)
         s_nxt.armed = 1'h0;
      else if (rearm)
         s_nxt.armed = 1'h1;
      if (ana_trig)
         s_nxt.last_rise = above;

      s_nxt.trig_pulse = trig_evt;
      // a new event beats an acknowledge in the same cycle
      s_nxt.trig_state = trig_evt | (s_r.trig_state & ~trig_ack_in);
      s_nxt.aux_prev = aux_sig;
      s_nxt.aux_state = aux_hit | (s_r.aux_state & ~aux_ack_in);

      unique case (s_r.seq.status)
         awts_pkg::AWTS_SEQ_NOT_READY:
         begin
            if (prog_ok)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_READY;
         end
         awts_pkg::AWTS_SEQ_READY:
         begin
            if (!prog_ok)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_NOT_READY;
            else if (seq_ctl_in.start)
            begin
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_RUN;
               s_nxt.seq.pc = '0;
            end
         end
         awts_pkg::AWTS_SEQ_RUN:
         begin
            if (!prog_ok)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_NOT_READY;
            else if (seq_ctl_in.stop)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_READY;
            else if (seq_ctl_in.wait_req & ~trig_evt)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_WAIT;
            else
               adv = 1'h1;
         end
         awts_pkg::AWTS_SEQ_WAIT:
         begin
            if (!prog_ok)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_NOT_READY;
            else if (seq_ctl_in.stop)
               s_nxt.seq.status = awts_pkg::AWTS_SEQ_READY;
            else if (trig_evt)
               adv = 1'h1;
         end
      endcase

      if (adv)
      begin
         if (!last)
         begin
            s_nxt.seq.status = awts_pkg::AWTS_SEQ_RUN;
            s_nxt.seq.pc = s_r.seq.pc + `AWTS_PC_ONE;
         end
         else if (seq_ctl_in.rerun)
         begin
            // restart costs no gap here; the host loop adds the jitter
            s_nxt.seq.status = awts_pkg::AWTS_SEQ_RUN;
            s_nxt.seq.pc = '0;
         end
         else
            s_nxt.seq.status = awts_pkg::AWTS_SEQ_READY;
      end

      s_nxt.seq.usage =
         usage_prod[`AWTS_USAGE_SHIFT +: `AWTS_USAGE_W];

      if (ct_err_in)
         s_nxt.seq.ct = awts_pkg::AWTS_CT_ERR;
      else if (ct_ok_in)
         s_nxt.seq.ct = awts_pkg::AWTS_CT_OK;
      else if (ct_clear_in)
         s_nxt.seq.ct = awts_pkg::AWTS_CT_NONE;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign trig_pulse_out = s_r.trig_pulse;
   assign trig_state_out = s_r.trig_state;
   assign aux_state_out = s_r.aux_state;
   assign seq_stat_out = s_r.seq;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_r);

   property p_force;
      force_in |=> (trig_pulse_out && trig_state_out);
   endproperty
   a_force: assert property (p_force)
      else $error("force did not trigger");

   property p_state_clear;
      (trig_state_out && trig_ack_in && !trig_evt) |=> !trig_state_out;
   endproperty
   a_state_clear: assert property (p_state_clear)
      else $error("trigger state not cleared");

   property p_pulse_sets_state;
      trig_pulse_out |-> trig_state_out;
   endproperty
   a_pulse_sets_state: assert property (p_pulse_sets_state)
      else $error("trigger pulse without state");

   property p_fall_no_high;
      (trig_cfg_in.slope == awts_pkg::AWTS_SLOPE_FALL && above &&
       !force_in) |=> !trig_pulse_out;
   endproperty
   a_fall_no_high: assert property (p_fall_no_high)
      else $error("falling slope fired while high");

   property p_below_level;
      (trig_cfg_in.slope == awts_pkg::AWTS_SLOPE_LEVEL &&
       samp_x < lvl_x && !force_in) |=> !trig_pulse_out;
   endproperty
   a_below_level: assert property (p_below_level)
      else $error("level trigger fired below level");

   property p_disarm;
      (ana_trig && hyst_nz) |=> (!s_r.armed && trig_pulse_out);
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("trigger not disarmed");

   property p_fall_rearm;
      (!s_r.armed && hyst_nz && !above_hi &&
       trig_cfg_in.slope == awts_pkg::AWTS_SLOPE_FALL) |=> !s_r.armed;
   endproperty
   a_fall_rearm: assert property (p_fall_rearm)
      else $error("re-armed on wrong side");

   property p_gate;
      (trig_cfg_in.gate_en && !gate_sig && !force_in) |=> !trig_pulse_out;
   endproperty
   a_gate: assert property (p_gate)
      else $error("gated trigger passed");

   property p_aux;
      aux_hit |=> aux_state_out;
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux trigger not recorded");

   property p_step;
      (seq_stat_out.status == awts_pkg::AWTS_SEQ_RUN && prog_ok &&
       !seq_ctl_in.stop && !seq_ctl_in.wait_req && !last) |=>
      (seq_stat_out.pc == $past(seq_stat_out.pc) + `AWTS_PC_ONE);
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step by one");

   property p_rerun;
      (seq_stat_out.status == awts_pkg::AWTS_SEQ_RUN && prog_ok && last &&
       seq_ctl_in.rerun && !seq_ctl_in.stop && !seq_ctl_in.wait_req) |=>
      (seq_stat_out.status == awts_pkg::AWTS_SEQ_RUN &&
       seq_stat_out.pc == '0);
   endproperty
   a_rerun: assert property (p_rerun)
      else $error("program not restarted");

   property p_too_long;
      (seq_ctl_in.len > `AWTS_CACHE_INSTR) [*2] |->
      (seq_stat_out.status == awts_pkg::AWTS_SEQ_NOT_READY);
   endproperty
   a_too_long: assert property (p_too_long)
      else $error("oversize program accepted");

   property p_ct_err;
      ct_err_in |=> (seq_stat_out.ct == awts_pkg::AWTS_CT_ERR);
   endproperty
   a_ct_err: assert property (p_ct_err)
      else $error("table error not shown");

endmodule

// ### include/awts_params.svh
// constants of the sequencer trigger and status block
`ifndef AWTS_PARAMS_SVH
`define AWTS_PARAMS_SVH

`define AWTS_SAMPLE_W 16
`define AWTS_CMP_W 20
`define AWTS_HYST_W 17
`define AWTS_HYST_MAX 17'h1FFFF
`define AWTS_PROD_W 32
`define AWTS_PCT_FULL 32'h00000064
`define AWTS_N_SRC 4
`define AWTS_SRC_SEL_W 2
`define AWTS_N_TRIG 4
`define AWTS_AUX_SEL_W 3
`define AWTS_GATE_IN_A 2
`define AWTS_GATE_IN_B 3
`define AWTS_CACHE_INSTR 11'h400
`define AWTS_LEN_W 11
`define AWTS_LEN_ONE 11'h001
`define AWTS_PC_W 10
`define AWTS_PC_ONE 10'h001
`define AWTS_USAGE_W 8
`define AWTS_USAGE_PROD_W 18
`define AWTS_USAGE_PCT 18'h00064
`define AWTS_USAGE_SHIFT 10
`define AWTS_INSTR_PERIOD_PS 4440
`define AWTS_CLK_PERIOD_PS 4000
`define AWTS_INSTR_CYCLES \
   (((`AWTS_INSTR_PERIOD_PS / `AWTS_CLK_PERIOD_PS) < 1) ? 1 : \
   (`AWTS_INSTR_PERIOD_PS / `AWTS_CLK_PERIOD_PS))

`endif

// ### include/awts_pkg.sv
// types of the sequencer trigger and status block
package awts_pkg;
`include "awts_params.svh"

   typedef enum logic [1:0]
   {
      AWTS_SLOPE_LEVEL = 2'h0,
      AWTS_SLOPE_RISE = 2'h1,
      AWTS_SLOPE_FALL = 2'h2,
      AWTS_SLOPE_BOTH = 2'h3
   } awts_slope_type;

   typedef enum logic [1:0]
   {
      AWTS_SEQ_NOT_READY = 2'h0,
      AWTS_SEQ_READY = 2'h1,
      AWTS_SEQ_RUN = 2'h2,
      AWTS_SEQ_WAIT = 2'h3
   } awts_seq_type;

   typedef enum logic [1:0]
   {
      AWTS_CT_NONE = 2'h0,
      AWTS_CT_OK = 2'h1,
      AWTS_CT_ERR = 2'h2
   } awts_ct_type;

   typedef struct packed
   {
      awts_slope_type slope;
      logic [`AWTS_SAMPLE_W-1:0] level;
      logic hyst_rel;
      logic [`AWTS_SAMPLE_W-1:0] hyst_abs;
      logic [`AWTS_SAMPLE_W-1:0] hyst_pct;
      logic [`AWTS_SAMPLE_W-1:0] full_scale;
      logic [`AWTS_SRC_SEL_W-1:0] src_sel;
      logic gate_en;
      logic gate_sel;
      logic [`AWTS_AUX_SEL_W-1:0] aux_sel;
   } awts_trig_cfg_type;

   typedef struct packed
   {
      logic loaded;
      logic [`AWTS_LEN_W-1:0] len;
      logic start;
      logic stop;
      logic rerun;
      logic wait_req;
   } awts_seq_ctl_type;

   typedef struct packed
   {
      awts_seq_type status;
      logic [`AWTS_PC_W-1:0] pc;
      logic [`AWTS_USAGE_W-1:0] usage;
      awts_ct_type ct;
   } awts_seq_stat_type;

   typedef struct packed
   {
      logic prev_above;
      logic armed;
      logic last_rise;
      logic trig_pulse;
      logic trig_state;
      logic aux_prev;
      logic aux_state;
      awts_seq_stat_type seq;
   } awts_state_type;

endpackage

// ### rtl/awts_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module awts_sync3
#(
   parameter int WIDTH = 4
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   typedef struct packed
   {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
      logic [WIDTH-1:0] ff3;
      logic [WIDTH-1:0] q;
   } awts_sync_state_type;

   awts_sync_state_type s_r;
   awts_sync_state_type s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ff1 = d_in;
      s_nxt.ff2 = s_r.ff1;
      s_nxt.ff3 = s_r.ff2;
      // a bit moves only once the two late stages agree
      s_nxt.q = (~(s_r.ff2 ^ s_r.ff3) & s_r.ff3) |
                ((s_r.ff2 ^ s_r.ff3) & s_r.q);
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign q_out = s_r.q;

endmodule

// ### verif/awts_pin_model.sv
// external trigger pin source with selectable skew
`timescale 1ns/1ps
module awts_pin_model
(
   input wire logic [3:0] req_in,
   input wire logic slow_in,
   output logic [3:0] pin_out
);
   initial pin_out = 4'h0;

   // pins are async to the clock: skew lands between edges
   always @(req_in)
   begin
      pin_out <= #(slow_in ? 7.3 : 0.9) req_in;
   end
endmodule

// ### verif/awts_top_tb_top.sv
// self-checking testbench of the sequencer trigger and status block
`timescale 1ns/1ps
`include "awts_params.svh"
module awts_top_tb_top;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [3:0][15:0] smp = '0;
   awts_pkg::awts_trig_cfg_type cfg = '0;
   awts_pkg::awts_seq_ctl_type ctl = '0;
   logic [5:0] pls = 6'h00;
   logic [3:0] preq = 4'h0;
   logic [3:0] tout = 4'h0;
   logic [3:0] pin;
   logic [3:0] pin_m = 4'h0;
   logic slow = 1'h0;
   logic pulse;
   logic tstate;
   logic astate;
   awts_pkg::awts_seq_stat_type stat;
   int miscompares = 0;
   int n_tests = 0;
   bit cmp_on = 1'h0;
   int m_prev = 0;
   int m_arm = 1;
   int m_rise = 0;
   int m_pls = 0;
   int m_st = 0;
   int m_sts = 0;
   int m_pc = 0;
   int m_ct = 0;
   int m_ok = 0;
   int m_use = 0;

   always #2 clk = ~clk;

   awts_top dut_u
   (
      .ref_clk_in(clk),
      .nrst_in(nrst),
      .samples_in(smp),
      .trig_cfg_in(cfg),
      .force_in(pls[0]),
      .trig_ack_in(pls[1]),
      .aux_ack_in(pls[2]),
      .trig_pin_in(pin),
      .trig_out_in(tout),
      .seq_ctl_in(ctl),
      .ct_ok_in(pls[3]),
      .ct_err_in(pls[4]),
      .ct_clear_in(pls[5]),
      .trig_pulse_out(pulse),
      .trig_state_out(tstate),
      .aux_state_out(astate),
      .seq_stat_out(stat)
   );

   awts_pin_model pm_u
   (
      .req_in(preq),
      .slow_in(slow),
      .pin_out(pin)
   );

   function automatic longint hyst_of();
      longint h;
      h = cfg.hyst_rel ? longint'(cfg.full_scale) * cfg.hyst_pct / 100
                       : longint'(cfg.hyst_abs);
      return h > `AWTS_HYST_MAX ? `AWTS_HYST_MAX : h;
   endfunction

   // reference model, one step per rising edge
   always @(posedge clk)
   begin
      int s, l, h, ab, hit, trg, sl, adv;
      s = $signed(smp[cfg.src_sel]);
      l = $signed(cfg.level);
      h = int'(hyst_of());
      sl = cfg.slope;
      ab = s >= l;
      hit = sl == 0 ? ab : sl == 1 ? ab && !m_prev : sl == 2 ?
            !ab && m_prev : ab != m_prev;
      hit = hit && (m_arm || h == 0) &&
            (!cfg.gate_en || pin_m[2 + cfg.gate_sel]);
      trg = hit || pls[0];
      if (hit && h != 0)
         m_arm = 0;
      else if (h == 0)
         m_arm = 1;
      else if (sl == 2 || (sl == 3 && !m_rise))
         m_arm |= s >= l + h;
      else
         m_arm |= s <= l - h;
      if (hit)
         m_rise = ab;
      m_prev = ab;
      m_st = trg || (m_st && !pls[1]);
      m_pls = trg;
      m_ok = ctl.loaded && ctl.len != 0 && ctl.len <= `AWTS_CACHE_INSTR;
      m_use = ctl.len * 100 / 1024;
      adv = 0;
      if (!m_ok)
         m_sts = 0;
      else if (m_sts == 0)
         m_sts = 1;
      else if (m_sts == 1)
      begin
         if (ctl.start)
         begin
            m_sts = 2;
            m_pc = 0;
         end
      end
      else if (ctl.stop)
         m_sts = 1;
      else if (m_sts == 3)
         adv = trg;
      else if (ctl.wait_req && !trg)
         m_sts = 3;
      else
         adv = 1;
      if (adv)
      begin
         m_sts = (m_pc == ctl.len - 1 && !ctl.rerun) ? 1 : 2;
         m_pc = m_pc == ctl.len - 1 ? 0 : m_pc + 1;
      end
      if (pls[4])
         m_ct = 2;
      else if (pls[3])
         m_ct = 1;
      else if (pls[5])
         m_ct = 0;
      if (!nrst)
      begin
         m_sts = 0;
         m_ct = 0;
         m_st = 0;
         m_pls = 0;
      end
   end

   task automatic check(input string nm, input logic [10:0] seen,
                        input logic [10:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   always @(negedge clk)
   begin
      if (cmp_on)
      begin
         check("pulse", 11'(pulse), 11'(m_pls));
         check("state", 11'(tstate), 11'(m_st));
         check("status", 11'(stat.status), 11'(m_sts));
         check("ctab", 11'(stat.ct), 11'(m_ct));
         if (m_sts >= 2)
            check("pc", 11'(stat.pc), 11'(m_pc));
         if (m_ok)
            check("usage", 11'(stat.usage), 11'(m_use));
      end
   end

   task tick();
      @(negedge clk);
      pls = 6'h00;
   endtask

   task set_pins(input logic [3:0] v);
      preq = v;
      slow = ~slow;
      repeat (8) tick();
      pin_m = v;
   endtask

   task seq_len(input logic [10:0] n, input int cyc);
      tick();
      ctl = '0;
      tick();
      ctl.loaded = 1'h1;
      ctl.len = n;
      repeat (2) tick();
      ctl.start = 1'h1;
      tick();
      ctl.start = 1'h0;
      repeat (cyc) tick();
   endtask

   task rand_blk(input int sl);
      seq_len(11'($urandom_range(6, 1)), 0);
      cfg.slope = awts_pkg::awts_slope_type'(sl);
      cfg.level = 16'($urandom);
      cfg.hyst_rel = 1'($urandom);
      cfg.hyst_abs = sl == 3 ? 16'h0000 : 16'($urandom_range(2000));
      cfg.hyst_pct = sl == 3 ? 16'h0000 : 16'($urandom_range(300));
      cfg.full_scale = 16'($urandom);
      cfg.src_sel = 2'($urandom);
      cfg.gate_en = 1'h0;
      repeat (150)
      begin
         tick();
         smp = {$urandom, $urandom};
         pls = 6'($urandom & $urandom) & (hyst_of() == 0 ? 6'h3F : 6'h3E);
         ctl.start = $urandom_range(7) == 0;
         ctl.stop = $urandom_range(31) == 0;
         ctl.wait_req = $urandom_range(3) == 0;
         ctl.rerun = 1'($urandom);
      end
   endtask

   task complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #60us;
      miscompares++;
      complete_run();
   end

   initial
   begin
      void'($urandom(32'h1321));
      cfg.level = 16'h7FFF;
      repeat (20) @(posedge clk);
      tick();
      nrst = 1'h1;
      cmp_on = 1'h1;
      repeat (4) tick();
      seq_len(11'h400, 1030);
      seq_len(11'h401, 8);
      seq_len(11'h000, 8);
      for (int k = 0; k < 12; k++)
         rand_blk(k % 4);
      // closed gate blocks level hits, force still passes
      for (int g = 0; g < 2; g++)
      begin
         cfg = '0;
         cfg.gate_en = 1'h1;
         cfg.gate_sel = g[0];
         smp = '1;
         set_pins(4'h8 >> g);
         smp = '0;
         repeat (3) tick();
         pls[0] = 1'h1;
         tick();
         smp = '1;
         set_pins(4'h4 << g);
         smp = '0;
         repeat (3) tick();
      end
      cfg.gate_en = 1'h0;
      for (int i = 0; i < 8; i++)
      begin
         cfg.aux_sel = i[2:0];
         tout = 4'h0;
         set_pins(4'h0);
         pls[2] = 1'h1;
         repeat (2) tick();
         check("aux_clr", 11'(astate), 11'h000);
         {tout, preq} = 8'h01 << (i ^ 1);
         set_pins(preq);
         check("aux_other", 11'(astate), 11'h000);
         {tout, preq} = 8'h01 << i;
         set_pins(preq);
         check("aux_set", 11'(astate), 11'h001);
      end
      complete_run();
   end
endmodule
